// file: rtl/irqu_top.sv
// Purpose: Pin and timer interrupt enables, sticky flags and vectoring
// Assumes: Timer events and counts come from logic on clk_sys
// Notes: Function
// Function
// - Pin 0 request forwarded only with its enable and global enable set
// - Pin 0 sensed by two-bit field; works while pin drives output
// - Accepted pin 0 request gives vector 0x001
// - Reserved bits of all mask and flag registers read zero
// - Pin 1 event sets pin 1 flag bit 7; vector 0x002
// - Pin 0 event sets pin 0 flag bit 6; vector 0x001
// - Pin flags clear on vector entry or on writing one
// - Timer 2 match sets flag bit 7; vector 0x003
// - Timer 2 overflow sets flag bit 6; vector 0x004
// - Timer 1 capture sets flag bit 5; vector 0x005
// - Timer 1 match A sets flag bit 4; vector 0x006
// - Timer 1 match B sets flag bit 3; vector 0x007
// - Timer 1 overflow sets flag bit 2; vector 0x008
// - Timer 0 overflow sets flag bit 0; vector 0x009
// - Timer flags clear on vector entry or on writing one
// - PWM mode: timer 2 overflow flag sets when count leaves 0x00
// - PWM mode: timer 1 overflow flag sets when count leaves 0x0000
// - Capture flag sets with the copy of timer 1 count
// - Entry clears global enable; return from interrupt sets it
// - Flags stay pending while disabled, then served by priority
// - Low-level sense keeps no flag, requests while pin is low
`timescale 1ns/10ps
module irqu_top
  import irqu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irqu_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic ext_pin0_irq,
  input wire logic ext_pin1_irq,
  // Timer units
  input wire irqu_pkg::irqu_tmr_evt_s tmr_evt,
  input wire logic t2_pwm_mode,
  input wire logic [7:0] t2_count,
  input wire logic t1_pwm_mode,
  input wire logic [15:0] t1_count,
  output logic [15:0] t1_capture_value,
  // CPU core
  output logic irq_req,
  output logic [irqu_pkg::VEC_W-1:0] irq_vector,
  input wire logic cpu_ack,
  input wire logic return_from_irq,
  output logic gie
);
  import irqu_pkg::*;

  irqu_apb_req_s req;
  logic [7:0] tflag_q, tflag_d, tmask_q, pflag_q, pflag_d, pmask_q;
  logic [7:0] ctrl_q, rd_byte;
  logic gie_q;
  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [1:0] edge_hit, level_req;
  irqu_sense_e mode0, mode1;
  logic [7:0] t2_cnt_q;
  logic [15:0] t1_cnt_q, cap_q;
  logic [7:0] tset, wclr_t, wclr_p, aclr_t, aclr_p;
  logic [NSRC-1:0] pend, en, act, ack_clr;
  logic [VEC_W-1:0] sel_idx, vec_q;
  logic hit, req_q, ack_ok;
  logic [31:0] prdata_q;
  logic wr_acc, mapped;
  logic [9:0] idx;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign idx = req.paddr[AW-1:2];
  assign wr_acc = req.psel & req.penable & req.pwrite;
  assign mapped = (idx == IDX_CTRL) | (idx == IDX_TFLAG) |
                  (idx == IDX_TMASK) | (idx == IDX_PFLAG) |
                  (idx == IDX_PMASK) | (idx == IDX_STAT);

  // APB answer: one wait-free access phase
  assign pready = req.psel & req.penable;
  assign pslverr = req.psel & req.penable & ~mapped;
  assign prdata = prdata_q;

  always_comb begin
    rd_byte = RST_BYTE;
    case (idx)
      IDX_CTRL: rd_byte = ctrl_q & CTRL_BITS;
      IDX_TFLAG: rd_byte = tflag_q & TMR_BITS;
      IDX_TMASK: rd_byte = tmask_q & TMR_BITS;
      IDX_PFLAG: rd_byte = pflag_q & PIN_BITS;
      IDX_PMASK: rd_byte = pmask_q & PIN_BITS;
      IDX_STAT: rd_byte = {gie_q, 7'h00};
      default: rd_byte = RST_BYTE;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (req.psel & ~req.penable) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Enable and sense control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmask_q <= RST_BYTE;
      pmask_q <= RST_BYTE;
      ctrl_q <= RST_BYTE;
    end else if (wr_acc) begin
      if (idx == IDX_TMASK) begin
        tmask_q <= req.pwdata[7:0] & TMR_BITS;
      end
      if (idx == IDX_PMASK) begin
        pmask_q <= req.pwdata[7:0] & PIN_BITS;
      end
      if (idx == IDX_CTRL) begin
        ctrl_q <= req.pwdata[7:0] & CTRL_BITS;
      end
    end
  end

  // Global enable: software write, then entry and return override
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gie_q <= 1'b0;
    end else if (ack_ok) begin
      gie_q <= 1'b0;
    end else if (return_from_irq) begin
      gie_q <= 1'b1;
    end else if (wr_acc && idx == IDX_STAT) begin
      gie_q <= req.pwdata[GIE_BIT];
    end
  end
  assign gie = gie_q;

  // Pin synchronisers plus one stage for edge history
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 2'b11;
      pin_s2_q <= 2'b11;
      pin_s3_q <= 2'b11;
    end else begin
      pin_s1_q <= {ext_pin1_irq, ext_pin0_irq};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign mode0 = irqu_sense_e'(ctrl_q[SENSE0_LSB+:2]);
  assign mode1 = irqu_sense_e'(ctrl_q[SENSE1_LSB+:2]);

  // Pin level seen whatever the pin direction
  always_comb begin
    edge_hit = 2'b00;
    level_req = 2'b00;
    case (mode0)
      SENSE_LOW: level_req[0] = ~pin_s2_q[0];
      SENSE_FALL: edge_hit[0] = pin_s3_q[0] & ~pin_s2_q[0];
      SENSE_RISE: edge_hit[0] = ~pin_s3_q[0] & pin_s2_q[0];
      default: edge_hit[0] = 1'b0;
    endcase
    case (mode1)
      SENSE_LOW: level_req[1] = ~pin_s2_q[1];
      SENSE_FALL: edge_hit[1] = pin_s3_q[1] & ~pin_s2_q[1];
      SENSE_RISE: edge_hit[1] = ~pin_s3_q[1] & pin_s2_q[1];
      default: edge_hit[1] = 1'b0;
    endcase
  end

  // Count history for PWM-mode overflow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t2_cnt_q <= T2_ZERO;
      t1_cnt_q <= T1_ZERO;
    end else begin
      t2_cnt_q <= t2_count;
      t1_cnt_q <= t1_count;
    end
  end

  // Capture copy taken with the flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_q <= T1_ZERO;
    end else if (tmr_evt.t1_capture) begin
      cap_q <= t1_count;
    end
  end
  assign t1_capture_value = cap_q;

  // Timer flag set terms
  always_comb begin
    tset = RST_BYTE;
    tset[T2M_BIT] = tmr_evt.t2_match;
    tset[T2W_BIT] = t2_pwm_mode ?
        (t2_cnt_q == T2_ZERO && t2_count != T2_ZERO) :
        tmr_evt.t2_wrap;
    tset[T1C_BIT] = tmr_evt.t1_capture;
    tset[T1A_BIT] = tmr_evt.t1_match_a;
    tset[T1B_BIT] = tmr_evt.t1_match_b;
    tset[T1W_BIT] = t1_pwm_mode ?
        (t1_cnt_q == T1_ZERO && t1_count != T1_ZERO) :
        tmr_evt.t1_wrap;
    tset[T0W_BIT] = tmr_evt.t0_wrap;
  end

  // Source order: index i has vector i + 1
  assign pend = {tflag_q[T0W_BIT], tflag_q[T1W_BIT], tflag_q[T1B_BIT],
                 tflag_q[T1A_BIT], tflag_q[T1C_BIT], tflag_q[T2W_BIT],
                 tflag_q[T2M_BIT], pflag_q[PIN1_BIT] | level_req[1],
                 pflag_q[PIN0_BIT] | level_req[0]};
  assign en = {tmask_q[T0W_BIT], tmask_q[T1W_BIT], tmask_q[T1B_BIT],
               tmask_q[T1A_BIT], tmask_q[T1C_BIT], tmask_q[T2W_BIT],
               tmask_q[T2M_BIT], pmask_q[PIN1_BIT], pmask_q[PIN0_BIT]};
  assign act = pend & en & {NSRC{gie_q}};

  // Lowest index found last wins
  always_comb begin
    sel_idx = '0;
    hit = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (act[i]) begin
        sel_idx = 4'(i);
        hit = 1'b1;
      end
    end
  end

  // Registered request and vector towards the core
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      vec_q <= '0;
    end else begin
      req_q <= hit & ~ack_ok;
      vec_q <= sel_idx + VEC_BASE;
    end
  end
  assign irq_req = req_q;
  assign irq_vector = vec_q;
  assign ack_ok = cpu_ack & req_q;
  assign ack_clr = ack_ok ? (9'h001 << (vec_q - VEC_BASE)) : 9'h000;

  // Clear terms from software and from vector entry
  assign wclr_t = (wr_acc && idx == IDX_TFLAG) ? req.pwdata[7:0] : 8'h00;
  assign wclr_p = (wr_acc && idx == IDX_PFLAG) ? req.pwdata[7:0] : 8'h00;
  always_comb begin
    aclr_t = 8'h00;
    aclr_p = 8'h00;
    aclr_p[PIN0_BIT] = ack_clr[0];
    aclr_p[PIN1_BIT] = ack_clr[1];
    aclr_t[T2M_BIT] = ack_clr[2];
    aclr_t[T2W_BIT] = ack_clr[3];
    aclr_t[T1C_BIT] = ack_clr[4];
    aclr_t[T1A_BIT] = ack_clr[5];
    aclr_t[T1B_BIT] = ack_clr[6];
    aclr_t[T1W_BIT] = ack_clr[7];
    aclr_t[T0W_BIT] = ack_clr[8];
  end

  // Set beats clear in the same cycle
  assign tflag_d = ((tflag_q & ~wclr_t & ~aclr_t) | tset) & TMR_BITS;
  assign pflag_d = ((pflag_q & ~wclr_p & ~aclr_p) |
                    {edge_hit, 6'h00}) & PIN_BITS;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tflag_q <= RST_BYTE;
      pflag_q <= RST_BYTE;
    end else begin
      tflag_q <= tflag_d;
      pflag_q <= pflag_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  pin0_gate_a: assert property (irq_req && irq_vector == 4'h1 |->
      $past(gie_q) && $past(pmask_q[PIN0_BIT]))
    else $error("pin 0 request without enables");
  pin0_edge_a: assert property (mode0 == SENSE_RISE &&
      $rose(pin_s2_q[0]) |=> pflag_q[PIN0_BIT])
    else $error("pin 0 rising edge missed");
  pin0_vec_a: assert property (act[0] && !ack_ok |=>
      irq_req && irq_vector == 4'h1)
    else $error("pin 0 vector wrong");
  rsvd_zero_a: assert property (req.psel && !req.penable &&
      idx == IDX_TFLAG |=> prdata[1] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("reserved bits read nonzero");
  pin1_flag_a: assert property (edge_hit[1] |=> pflag_q[PIN1_BIT])
    else $error("pin 1 flag not set");
  pin0_flag_a: assert property (edge_hit[0] |=> pflag_q[PIN0_BIT])
    else $error("pin 0 flag not set");
  pin_w1c_a: assert property (wr_acc && idx == IDX_PFLAG &&
      req.pwdata[PIN1_BIT] && !edge_hit[1] |=> !pflag_q[PIN1_BIT])
    else $error("pin 1 flag not cleared by write");
  pin_w0k_a: assert property (wr_acc && idx == IDX_PFLAG &&
      !req.pwdata[PIN1_BIT] && pflag_q[PIN1_BIT] && !ack_clr[1]
      |=> pflag_q[PIN1_BIT])
    else $error("pin 1 flag lost on zero write");
  t2_match_a: assert property (tmr_evt.t2_match ##1 (gie_q &&
      tmask_q[T2M_BIT] && act[1:0] == 2'b00 && !ack_ok) |=>
      irq_req && irq_vector == 4'h3)
    else $error("timer 2 match not vectored");
  t2_wrap_a: assert property (!t2_pwm_mode && tmr_evt.t2_wrap |=>
      tflag_q[T2W_BIT])
    else $error("timer 2 overflow flag missed");
  t1_cap_a: assert property (tmr_evt.t1_capture |=>
      tflag_q[T1C_BIT] && t1_capture_value == $past(t1_count))
    else $error("capture flag or copy wrong");
  t1_ma_a: assert property (tmr_evt.t1_match_a |=> tflag_q[T1A_BIT])
    else $error("match A flag missed");
  t1_mb_a: assert property (tmr_evt.t1_match_b |=> tflag_q[T1B_BIT])
    else $error("match B flag missed");
  t1_wrap_a: assert property (!t1_pwm_mode && tmr_evt.t1_wrap |=>
      tflag_q[T1W_BIT])
    else $error("timer 1 overflow flag missed");
  t0_wrap_a: assert property (tmr_evt.t0_wrap |=> tflag_q[T0W_BIT])
    else $error("timer 0 overflow flag missed");
  ack_clear_a: assert property (ack_ok && vec_q == 4'h9 &&
      !tmr_evt.t0_wrap |=> !tflag_q[T0W_BIT])
    else $error("flag kept after vector entry");
  t2_pwm_a: assert property (t2_pwm_mode && t2_cnt_q == T2_ZERO &&
      t2_count != T2_ZERO |=> tflag_q[T2W_BIT])
    else $error("timer 2 PWM overflow missed");
  t1_pwm_a: assert property (t1_pwm_mode && t1_cnt_q == T1_ZERO &&
      t1_count != T1_ZERO |=> tflag_q[T1W_BIT])
    else $error("timer 1 PWM overflow missed");
  gie_entry_a: assert property (ack_ok |=> !gie ##1 !irq_req)
    else $error("global enable kept after entry");
  gie_ret_a: assert property (return_from_irq && !ack_ok |=> gie)
    else $error("global enable not restored");
  pend_hold_a: assert property (!gie_q && tflag_q[T0W_BIT] &&
      !wclr_t[T0W_BIT] && !return_from_irq && !(wr_acc && idx == IDX_STAT)
      |=> tflag_q[T0W_BIT] && !irq_req)
    else $error("pending flag lost or served while disabled");
  level_req_a: assert property (mode0 == SENSE_LOW && !pin_s2_q[0] &&
      pmask_q[PIN0_BIT] && gie_q && !ack_ok |=> irq_req)
    else $error("low level not requesting");
  prio_a: assert property (irq_req |->
      ($past(act) & ((9'h001 << (irq_vector - VEC_BASE)) - 9'h001))
      == 9'h000)
    else $error("lower vector pending but not chosen");
  pin1_fall_a: assert property (mode1 == SENSE_FALL &&
      $fell(pin_s2_q[1]) |=> pflag_q[PIN1_BIT])
    else $error("pin 1 falling edge missed");
  rsvd_sense_a: assert property (mode0 == SENSE_RSV &&
      !pflag_q[PIN0_BIT] |=> !pflag_q[PIN0_BIT])
    else $error("reserved sense set pin 0 flag");
  pin_rsvd_a: assert property (req.psel && !req.penable &&
      idx == IDX_PFLAG |=> prdata[5:0] == 6'h00)
    else $error("pin flag reserved bits nonzero");

  entry_c: cover property (irq_req ##1 cpu_ack ##1 return_from_irq);
  nest_c: cover property (act[0] && act[8]);
  level_c: cover property (mode1 == SENSE_LOW && irq_req &&
      irq_vector == 4'h2);
  race_c: cover property (wr_acc && idx == IDX_TFLAG && |(wclr_t & tset));
endmodule

// file: rtl/irqu_pkg.sv
// Purpose: Constants and types for the interrupt mask and flag unit
// Assumes: APB with 32-bit data, byte address is four times the index
// Notes: Only the low byte of each word is used
package irqu_pkg;
  localparam int unsigned NSRC = 9;
  localparam int unsigned VEC_W = 4;
  localparam int unsigned AW = 12;
  // Register indices
  localparam logic [9:0] IDX_CTRL = 10'h035;
  localparam logic [9:0] IDX_TFLAG = 10'h038;
  localparam logic [9:0] IDX_TMASK = 10'h039;
  localparam logic [9:0] IDX_PFLAG = 10'h03A;
  localparam logic [9:0] IDX_PMASK = 10'h03B;
  localparam logic [9:0] IDX_STAT = 10'h03F;
  // Implemented bits of each register
  localparam logic [7:0] TMR_BITS = 8'hFD;
  localparam logic [7:0] PIN_BITS = 8'hC0;
  localparam logic [7:0] CTRL_BITS = 8'h0F;
  localparam int unsigned PIN1_BIT = 7;
  localparam int unsigned PIN0_BIT = 6;
  localparam int unsigned GIE_BIT = 7;
  localparam int unsigned T2M_BIT = 7;
  localparam int unsigned T2W_BIT = 6;
  localparam int unsigned T1C_BIT = 5;
  localparam int unsigned T1A_BIT = 4;
  localparam int unsigned T1B_BIT = 3;
  localparam int unsigned T1W_BIT = 2;
  localparam int unsigned T0W_BIT = 0;
  localparam int unsigned SENSE0_LSB = 0;
  localparam int unsigned SENSE1_LSB = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [VEC_W-1:0] VEC_BASE = 4'h1;
  localparam logic [7:0] T2_ZERO = 8'h00;
  localparam logic [15:0] T1_ZERO = 16'h0000;
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_RSV = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } irqu_sense_e;
  typedef struct packed {
    logic t2_match;
    logic t2_wrap;
    logic t1_capture;
    logic t1_match_a;
    logic t1_match_b;
    logic t1_wrap;
    logic t0_wrap;
  } irqu_tmr_evt_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
  } irqu_apb_req_s;
endpackage

// file: bench/irqu_cpu_model.sv
// Purpose: CPU core stand-in that takes vectors and returns
// Assumes: Ack only while irq_req is high
// Notes: ack_delay sets how slowly each vector is taken
`timescale 1ns/10ps
module irqu_cpu_model
  import irqu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Design side
  input wire logic irq_req,
  input wire logic [irqu_pkg::VEC_W-1:0] irq_vector,
  output logic cpu_ack,
  output logic return_from_irq,
  // Control and log
  input wire logic [3:0] ack_delay,
  input wire logic auto_ret,
  output logic taken
);
  logic [3:0] wait_q;
  logic [3:0] ret_q;
  assign taken = cpu_ack && irq_req;
  // Ack one cycle, then restart the delay count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (cpu_ack || !irq_req) begin
      cpu_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q == ack_delay) begin
      cpu_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // Short handler, then return
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ret_q <= 4'h0;
      return_from_irq <= 1'b0;
    end else begin
      ret_q <= taken ? 4'h3 : (ret_q != 4'h0 ? ret_q - 4'h1 : 4'h0);
      return_from_irq <= auto_ret && ret_q == 4'h1;
    end
  end
endmodule

// file: bench/tb_irq_mask_flag_unit.sv
// Purpose: Self-checking bench for the interrupt mask and flag unit
// Assumes: Zero wait APB slave, CPU model on the vector side
// Notes: Expected flags and vectors come from a bench model
`timescale 1ns/10ps
module tb_irq_mask_flag_unit;
  import irqu_pkg::*;
  logic clk_sys, rst_n, pready, pslverr, ext_pin0_irq, ext_pin1_irq;
  logic t2_pwm_mode, t1_pwm_mode, irq_req, cpu_ack, return_from_irq;
  logic gie, auto_ret, taken, slv_q;
  logic [31:0] prdata, rd_q;
  logic [7:0] t2_count, ex;
  logic [15:0] t1_count, t1_capture_value, cap;
  logic [3:0] irq_vector, ack_delay;
  logic [3:0] seen_q[$];
  logic [3:0] exp_q[$];
  logic [6:0] m;
  irqu_tmr_evt_s tmr_evt;
  irqu_apb_req_s req;
  int err_count, check_count;
  irqu_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(req.psel),
    .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
    .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pin0_irq(ext_pin0_irq),
    .ext_pin1_irq(ext_pin1_irq), .tmr_evt(tmr_evt),
    .t2_pwm_mode(t2_pwm_mode), .t2_count(t2_count),
    .t1_pwm_mode(t1_pwm_mode), .t1_count(t1_count),
    .t1_capture_value(t1_capture_value), .irq_req(irq_req),
    .irq_vector(irq_vector), .cpu_ack(cpu_ack),
    .return_from_irq(return_from_irq), .gie(gie));
  irqu_cpu_model i_cpu (.clk_sys(clk_sys), .rst_n(rst_n),
    .irq_req(irq_req), .irq_vector(irq_vector), .cpu_ack(cpu_ack),
    .return_from_irq(return_from_irq), .ack_delay(ack_delay),
    .auto_ret(auto_ret), .taken(taken));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (taken === 1'b1) seen_q.push_back(irq_vector);
  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic fail_out();
    err_count++;
    results();
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [9:0] idx, logic [7:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_out();
    rd_q = prdata;
    slv_q = pslverr;
    req <= '0;
  endtask
  task automatic wr(logic [9:0] idx, logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdchk(string what, logic [9:0] idx, logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    check(what, rd_q, {24'h0, e});
  endtask
  task automatic pulse(logic [6:0] v);
    @(posedge clk_sys);
    tmr_evt <= v;
    @(posedge clk_sys);
    tmr_evt <= '0;
  endtask
  task automatic serve(int n);
    int c;
    c = 0;
    while (seen_q.size() < n && c < 500) begin
      @(posedge clk_sys);
      c++;
    end
    if (c >= 500) fail_out();
    while (exp_q.size() > 0)
      check("vector", {28'h0, seen_q.pop_front()},
        {28'h0, exp_q.pop_front()});
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    ext_pin0_irq = 1'b1;
    ext_pin1_irq = 1'b0;
    tmr_evt = '0;
    t2_pwm_mode = 1'b0;
    t1_pwm_mode = 1'b0;
    t2_count = 8'h00;
    t1_count = 16'h0000;
    ack_delay = 4'h0;
    auto_ret = 1'b1;
    err_count = 0;
    check_count = 0;
    cap = 16'($urandom(32'hC4DB));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk("tflag", IDX_TFLAG, 8'h00);
    rdchk("pflag", IDX_PFLAG, 8'h00);
    wr(IDX_TMASK, 8'hFF);
    rdchk("tmask", IDX_TMASK, TMR_BITS);
    wr(IDX_PMASK, 8'hFF);
    rdchk("pmask", IDX_PMASK, PIN_BITS);
    wr(IDX_TFLAG, 8'hFF);
    rdchk("tflag", IDX_TFLAG, 8'h00);
    wr(IDX_PMASK, 8'h00);
    wr(10'h000, 8'hFF);
    check("err", {31'h0, slv_q}, 32'h1);
    rdchk("unmapped", 10'h000, 8'h00);
    for (int r = 0; r < 4; r++) begin
      m = (r == 0) ? 7'h7F : 7'($urandom);
      wr(IDX_TMASK, 8'h00);
      pulse(m);
      ex = {m[6:1], 1'b0, m[0]};
      rdchk("tflag", IDX_TFLAG, ex);
      if (r == 0) begin
        wr(IDX_TFLAG, 8'h01);
        wr(IDX_TFLAG, 8'h00);
        m[0] = 1'b0;
        rdchk("tflag", IDX_TFLAG, 8'hFC);
      end
      for (int k = 6; k >= 0; k--) if (m[k]) exp_q.push_back(4'(9 - k));
      ack_delay <= 4'($urandom_range(0, 5));
      wr(IDX_TMASK, TMR_BITS);
      repeat (2) @(posedge clk_sys);
      check("req", {31'h0, irq_req}, 32'h0);
      wr(IDX_STAT, 8'h80);
      serve(exp_q.size());
      repeat (8) @(posedge clk_sys);
      check("gie", {31'h0, gie}, 32'h1);
      rdchk("tflag", IDX_TFLAG, 8'h00);
      wr(IDX_STAT, 8'h00);
    end
    wr(IDX_TMASK, 8'h00);
    wr(IDX_CTRL, 8'h0E);
    rdchk("ctrl", IDX_CTRL, 8'h0E);
    ext_pin0_irq <= 1'b0;
    ext_pin1_irq <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdchk("pflag", IDX_PFLAG, 8'hC0);
    wr(IDX_PFLAG, 8'h40);
    wr(IDX_PFLAG, 8'h00);
    rdchk("pflag", IDX_PFLAG, 8'h80);
    ext_pin0_irq <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_pin0_irq <= 1'b0;
    wr(IDX_PMASK, 8'h80);
    wr(IDX_STAT, 8'h80);
    exp_q.push_back(4'h2);
    serve(1);
    repeat (10) @(posedge clk_sys);
    check("req", {31'h0, irq_req}, 32'h0);
    wr(IDX_PMASK, 8'hC0);
    exp_q.push_back(4'h1);
    serve(1);
    rdchk("pflag", IDX_PFLAG, 8'h00);
    auto_ret <= 1'b0;
    repeat (8) @(posedge clk_sys);
    wr(IDX_CTRL, 8'h0C);
    exp_q.push_back(4'h1);
    serve(1);
    rdchk("pflag", IDX_PFLAG, 8'h00);
    ext_pin0_irq <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(IDX_STAT, 8'h80);
    repeat (6) @(posedge clk_sys);
    check("req", {31'h0, irq_req}, 32'h0);
    wr(IDX_STAT, 8'h00);
    // Pin 0 rising and pin 1 falling sense, then reserved sense
    wr(IDX_CTRL, 8'h0B);
    ext_pin0_irq <= 1'b0;
    ext_pin1_irq <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rdchk("pflag", IDX_PFLAG, 8'h80);
    ext_pin0_irq <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdchk("pflag", IDX_PFLAG, 8'hC0);
    wr(IDX_PFLAG, 8'hC0);
    wr(IDX_CTRL, 8'h05);
    ext_pin0_irq <= 1'b0;
    ext_pin1_irq <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdchk("pflag", IDX_PFLAG, 8'h00);
    t2_pwm_mode <= 1'b1;
    t1_pwm_mode <= 1'b1;
    pulse(7'h22);
    rdchk("tflag", IDX_TFLAG, 8'h00);
    t2_count <= 8'h01;
    t1_count <= 16'h0001;
    rdchk("tflag", IDX_TFLAG, 8'h44);
    wr(IDX_TFLAG, 8'h44);
    t1_pwm_mode <= 1'b0;
    t1_count <= cap;
    pulse(7'h10);
    rdchk("tflag", IDX_TFLAG, 8'h20);
    check("capture", {16'h0, t1_capture_value}, {16'h0, cap});
    results();
  end
endmodule
